// [rtl/rtci_host.sv]
// Purpose: Host end: byte-level two-wire bus master
// Assumes: One command at a time, handshake on cmd_ready
// Notes:   SCL made by a quarter-period divider of clk
`timescale 1ns/1ps
`default_nettype none
module rtci_host
  import rtci_pkg::*;
#(
  parameter logic [15:0] QTR = 16'(QTR_CYC)
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       cmd_valid,
  input  wire rtci_cmd_t  cmd_code,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_last,
  rtci_if.host            bus,
  output logic            cmd_ready,
  output logic            done,
  output logic      [7:0] rd_byte,
  output logic            nack,
  output logic            refused
);
  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_STOP  = 4'h4,
    H_BYTE  = 4'h8
  } rtci_hst_t;

  rtci_hst_t   st_ff;
  rtci_hst_t   nxt_st;
  logic [15:0] q_ff;
  logic [15:0] nxt_q;
  logic [1:0]  ph_ff;
  logic [1:0]  nxt_ph;
  logic [3:0]  bit_ff;
  logic [3:0]  nxt_bit;
  logic [7:0]  sh_ff;
  logic [7:0]  nxt_sh;
  logic        rd_ff;
  logic        nxt_rd;
  logic        last_ff;
  logic        nxt_last;
  logic        lock_ff;
  logic        nxt_lock;
  logic        scl_oe_ff;
  logic        nxt_scl_oe;
  logic        sda_oe_ff;
  logic        nxt_sda_oe;
  logic        ready_ff;
  logic        nxt_ready;
  logic        done_ff;
  logic        nxt_done;
  logic [7:0]  rdb_ff;
  logic [7:0]  nxt_rdb;
  logic        nack_ff;
  logic        nxt_nack;
  logic        ref_ff;
  logic        nxt_ref;
  logic        sda_s;

  rtci_sync #(.W(1), .INIT(1'b1)) u_sync (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .d     (bus.sda),
    .q     (sda_s),
    .q_d   ()
  );

  wire       tick    = q_ff == QTR - 16'h0001;
  wire       is_byte = cmd_code == CMD_WRITE || cmd_code == CMD_READ;
  wire [3:0] bit_nx  = bit_ff + 4'h1;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    nxt_st     = st_ff;
    nxt_q      = q_ff;
    nxt_ph     = ph_ff;
    nxt_bit    = bit_ff;
    nxt_sh     = sh_ff;
    nxt_rd     = rd_ff;
    nxt_last   = last_ff;
    nxt_lock   = lock_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_ready  = ready_ff;
    nxt_done   = 1'b0;
    nxt_rdb    = rdb_ff;
    nxt_nack   = nack_ff;
    nxt_ref    = 1'b0;
    if (st_ff == H_IDLE) begin
      nxt_ready = 1'b1;
      nxt_q     = 16'h0000;
      nxt_ph    = 2'h0;
      if (cmd_valid && ready_ff && is_byte && lock_ff) begin
        nxt_done = 1'b1;
        nxt_ref  = 1'b1;
      end else if (cmd_valid && ready_ff) begin
        nxt_ready = 1'b0;
        case (cmd_code)
          CMD_START: begin
            nxt_st     = H_START;
            nxt_sda_oe = 1'b0;
            nxt_lock   = 1'b0;
          end
          CMD_STOP: begin
            nxt_st     = H_STOP;
            nxt_sda_oe = 1'b1;
            nxt_lock   = 1'b0;
          end
          default: begin
            nxt_st     = H_BYTE;
            nxt_bit    = 4'h0;
            nxt_rd     = cmd_code == CMD_READ;
            nxt_last   = cmd_last;
            nxt_sh     = (cmd_code == CMD_READ) ? 8'hff : cmd_data;
            nxt_sda_oe = (cmd_code == CMD_WRITE) & !cmd_data[7];
          end
        endcase
      end
    end else if (!tick) begin
      nxt_q = q_ff + 16'h0001;
    end else begin
      nxt_q  = 16'h0000;
      nxt_ph = ph_ff + 2'h1;
      case (st_ff)
        H_START: begin
          case (ph_ff)
            2'h0:    nxt_scl_oe = 1'b0;
            2'h1:    nxt_sda_oe = 1'b1;
            2'h2:    nxt_scl_oe = 1'b1;
            default: begin
              nxt_st   = H_IDLE;
              nxt_done = 1'b1;
            end
          endcase
        end
        H_STOP: begin
          case (ph_ff)
            2'h0:    nxt_scl_oe = 1'b0;
            2'h1:    nxt_sda_oe = 1'b0;
            default: begin
              nxt_st   = H_IDLE;
              nxt_done = 1'b1;
            end
          endcase
        end
        H_BYTE: begin
          case (ph_ff)
            2'h0: nxt_scl_oe = 1'b0;
            2'h1: begin
              if (bit_ff == ACK_SLOT) begin
                nxt_nack = sda_s;
              end else begin
                nxt_sh = {sh_ff[6:0], sda_s};
              end
            end
            2'h2: nxt_scl_oe = 1'b1;
            default: begin
              nxt_bit = bit_nx;
              if (bit_ff == ACK_SLOT) begin
                nxt_st     = H_IDLE;
                nxt_done   = 1'b1;
                nxt_rdb    = sh_ff;
                nxt_sda_oe = 1'b0;
                nxt_lock   = rd_ff & last_ff;
              end else if (bit_nx == ACK_SLOT) begin
                nxt_sda_oe = rd_ff & !last_ff;
              end else begin
                nxt_sda_oe = !rd_ff & !sh_ff[7];
              end
            end
          endcase
        end
        default: nxt_st = H_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff     <= H_IDLE;
      q_ff      <= 16'h0000;
      ph_ff     <= 2'h0;
      bit_ff    <= 4'h0;
      sh_ff     <= 8'h00;
      rd_ff     <= 1'b0;
      last_ff   <= 1'b0;
      lock_ff   <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ready_ff  <= 1'b0;
      done_ff   <= 1'b0;
      rdb_ff    <= 8'h00;
      nack_ff   <= 1'b0;
      ref_ff    <= 1'b0;
    end else if (ce) begin
      st_ff     <= nxt_st;
      q_ff      <= nxt_q;
      ph_ff     <= nxt_ph;
      bit_ff    <= nxt_bit;
      sh_ff     <= nxt_sh;
      rd_ff     <= nxt_rd;
      last_ff   <= nxt_last;
      lock_ff   <= nxt_lock;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      ready_ff  <= nxt_ready;
      done_ff   <= nxt_done;
      rdb_ff    <= nxt_rdb;
      nack_ff   <= nxt_nack;
      ref_ff    <= nxt_ref;
    end
  end

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = scl_oe_ff;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = sda_oe_ff;
  assign cmd_ready    = ready_ff;
  assign done         = done_ff;
  assign rd_byte      = rdb_ff;
  assign nack         = nack_ff;
  assign refused      = ref_ff;
endmodule // rtci_host
`default_nettype wire

// [rtl/rtci_pkg.sv]
// Purpose: Shared constants and types for the two-wire RTC register port
// Assumes: 125 MHz system clock on both ends
// Notes:   Timing counts derive from periods in ns
package rtci_pkg;
  // --------------------------------------------------------------------
  // Addressing
  // --------------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR  = 7'h51;
  localparam logic [7:0] ADDR_WR   = {DEV_ADDR, 1'b0};
  localparam logic [7:0] ADDR_RD   = {DEV_ADDR, 1'b1};
  localparam logic [7:0] PTR_MAX   = 8'h2f;
  localparam logic [5:0] PTR_RST   = 6'h00;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [3:0] ACK_SLOT  = 4'h8;
  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) /
                           (4 * CLK_PERIOD_NS);
  // --------------------------------------------------------------------
  // Host commands
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_STOP  = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_READ  = 2'h3
  } rtci_cmd_t;
endpackage

// [rtl/rtci_if.sv]
// Purpose: Two-wire bus carrier joining host and device ends
// Assumes: Open-drain lines with pull-ups
// Notes:   Line level resolved from the output enables
`timescale 1ns/1ps
`default_nettype none
interface rtci_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // --------------------------------------------------------------------
  // Wired-AND resolution
  // --------------------------------------------------------------------
  assign scl = !(m_scl_oe & !m_scl_o);
  assign sda = !((m_sda_oe & !m_sda_o) | (s_sda_oe & !s_sda_o));

  modport dev  (input scl, input sda, output s_sda_o, output s_sda_oe);
  modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
                output m_sda_o, output m_sda_oe);
endinterface
`default_nettype wire

// [rtl/rtci_sync.sv]
// Purpose: Two-flop synchroniser with one delayed copy for edge finding
// Assumes: Inputs asynchronous to clk
// Notes:   First stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module rtci_sync #(
  parameter int           W    = 2,
  parameter logic [W-1:0] INIT = '1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] q_d
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] dly_ff;

  // --------------------------------------------------------------------
  // Per-line stages
  // --------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_line
      always_ff @(posedge clk) begin
        if (reset) begin
          meta_ff[i] <= INIT[i];
          sync_ff[i] <= INIT[i];
          dly_ff[i]  <= INIT[i];
        end else if (ce) begin
          meta_ff[i] <= d[i];
          sync_ff[i] <= meta_ff[i];
          dly_ff[i]  <= sync_ff[i];
        end
      end
    end
  endgenerate

  assign q   = sync_ff;
  assign q_d = dly_ff;
endmodule // rtci_sync
`default_nettype wire

// [rtl/rtci_dev.sv]
// Purpose: Device end of the two-wire register port of an RTC
// Assumes: Register file outside answers rd_data for ptr combinationally
// Notes:   Samples both lines at clk; no clock stretching
//
// Contract
// - SDA fall with SCL high starts transaction
// - SDA rise with SCL high stops transaction
// - Each byte followed by one acknowledge bit
// - Device acknowledges every byte written to it
// - Master acks wanted bytes, nacks last one
// - Master sends stop or restart after nack
// - First write byte loads pointer, 00h..2Fh
// - Bad pointer ignores transfer, still acknowledged
// - Any number of write data bytes allowed
// - Store byte at pointer, increment, wrap 2Fh
// - Read starts at current pointer location
// - Master sets pointer by pointer-only write
// - After read address ack, shift data out
// - Increment after read byte; stop on nack
// - Respond only to address 1010001, bit0 R/W
// - Master sends address byte right after start
// - SDA stable while SCL high, else condition
// - Interface disabled while on battery
`timescale 1ns/1ps
`default_nettype none
module rtci_dev
  import rtci_pkg::*;
#(
  parameter logic [6:0] ADDR = DEV_ADDR
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       on_battery,
  rtci_if.dev             bus,
  input  wire logic [7:0] rd_data,
  output logic      [5:0] ptr,
  output logic      [7:0] wr_data,
  output logic            wr_en,
  output logic            busy
);
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_RX   = 6'h04,
    S_ACK  = 6'h08,
    S_TX   = 6'h10,
    S_MACK = 6'h20
  } rtci_dst_t;

  rtci_dst_t  st_ff;
  rtci_dst_t  nxt_st;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic       rw_ff;
  logic       nxt_rw;
  logic       gotp_ff;
  logic       nxt_gotp;
  logic       ign_ff;
  logic       nxt_ign;
  logic       ackd_ff;
  logic       nxt_ackd;
  logic       oe_ff;
  logic       nxt_oe;
  logic [5:0] ptr_ff;
  logic [5:0] nxt_ptr;
  logic [7:0] wd_ff;
  logic [7:0] nxt_wd;
  logic       we_ff;
  logic       nxt_we;
  logic       busy_ff;

  // --------------------------------------------------------------------
  // Line sampling and conditions
  // --------------------------------------------------------------------
  logic [2:0] ln_q;
  logic [2:0] ln_d;

  rtci_sync #(.W(3), .INIT(3'h3)) u_sync (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .d     ({on_battery, bus.scl, bus.sda}),
    .q     (ln_q),
    .q_d   (ln_d)
  );

  wire       bat      = ln_q[2];
  wire       scl      = ln_q[1];
  wire       sda      = ln_q[0];
  wire       scl_rise = scl & !ln_d[1];
  wire       scl_fall = !scl & ln_d[1];
  wire       scl_hi   = scl & ln_d[1];
  wire       start_c  = scl_hi & ln_d[0] & !sda;
  wire       stop_c   = scl_hi & !ln_d[0] & sda;
  wire [7:0] byte_w   = {sh_ff[6:0], sda};
  wire       addr_hit = byte_w[7:1] == ADDR;
  wire       ptr_ok   = byte_w <= PTR_MAX;
  wire       byte_end = scl_rise & (cnt_ff == BIT_LAST);
  wire [5:0] ptr_inc  = (ptr_ff == PTR_MAX[5:0]) ? PTR_RST
                                                 : ptr_ff + 6'h01;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    nxt_st   = st_ff;
    nxt_sh   = sh_ff;
    nxt_cnt  = cnt_ff;
    nxt_rw   = rw_ff;
    nxt_gotp = gotp_ff;
    nxt_ign  = ign_ff;
    nxt_ackd = ackd_ff;
    nxt_oe   = oe_ff;
    nxt_ptr  = ptr_ff;
    nxt_wd   = wd_ff;
    nxt_we   = 1'b0;
    if (bat) begin
      nxt_st = S_IDLE;
      nxt_oe = 1'b0;
    end else if (start_c) begin
      nxt_st   = S_ADDR;
      nxt_cnt  = 3'h0;
      nxt_gotp = 1'b0;
      nxt_ign  = 1'b0;
      nxt_oe   = 1'b0;
    end else if (stop_c) begin
      nxt_st = S_IDLE;
      nxt_oe = 1'b0;
    end else begin
      case (st_ff)
        S_ADDR, S_RX: begin
          if (scl_rise) begin
            nxt_sh  = byte_w;
            nxt_cnt = cnt_ff + 3'h1;
          end
          if (byte_end && st_ff == S_ADDR) begin
            if (addr_hit) begin
              nxt_rw   = sda;
              nxt_st   = S_ACK;
              nxt_ackd = 1'b0;
            end else begin
              nxt_st = S_IDLE;
            end
          end else if (byte_end) begin
            nxt_st   = S_ACK;
            nxt_ackd = 1'b0;
            if (!gotp_ff) begin
              nxt_gotp = 1'b1;
              if (ptr_ok) begin
                nxt_ptr = byte_w[5:0];
              end else begin
                nxt_ign = 1'b1;
              end
            end else if (!ign_ff) begin
              nxt_we  = 1'b1;
              nxt_wd  = byte_w;
              nxt_ptr = ptr_inc;
            end
          end
        end
        S_ACK: begin
          if (scl_fall && !ackd_ff) begin
            nxt_oe   = 1'b1;
            nxt_ackd = 1'b1;
          end else if (scl_fall) begin
            nxt_ackd = 1'b0;
            nxt_cnt  = 3'h0;
            if (rw_ff) begin
              nxt_st = S_TX;
              nxt_sh = rd_data;
              nxt_oe = !rd_data[7];
            end else begin
              nxt_st = S_RX;
              nxt_oe = 1'b0;
            end
          end
        end
        S_TX: begin
          if (scl_fall && cnt_ff == BIT_LAST) begin
            nxt_oe   = 1'b0;
            nxt_st   = S_MACK;
            nxt_ackd = 1'b0;
            nxt_ptr  = ptr_inc;
          end else if (scl_fall) begin
            nxt_cnt = cnt_ff + 3'h1;
            nxt_sh  = {sh_ff[6:0], 1'b0};
            nxt_oe  = !sh_ff[6];
          end
        end
        S_MACK: begin
          if (scl_rise && sda) begin
            nxt_st = S_IDLE;
          end else if (scl_rise) begin
            nxt_ackd = 1'b1;
          end else if (scl_fall && ackd_ff) begin
            nxt_st   = S_TX;
            nxt_cnt  = 3'h0;
            nxt_sh   = rd_data;
            nxt_oe   = !rd_data[7];
            nxt_ackd = 1'b0;
          end
        end
        default: begin
          nxt_st = S_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff   <= S_IDLE;
      sh_ff   <= 8'h00;
      cnt_ff  <= 3'h0;
      rw_ff   <= 1'b0;
      gotp_ff <= 1'b0;
      ign_ff  <= 1'b0;
      ackd_ff <= 1'b0;
      oe_ff   <= 1'b0;
      ptr_ff  <= PTR_RST;
      wd_ff   <= 8'h00;
      we_ff   <= 1'b0;
      busy_ff <= 1'b0;
    end else if (ce) begin
      st_ff   <= nxt_st;
      sh_ff   <= nxt_sh;
      cnt_ff  <= nxt_cnt;
      rw_ff   <= nxt_rw;
      gotp_ff <= nxt_gotp;
      ign_ff  <= nxt_ign;
      ackd_ff <= nxt_ackd;
      oe_ff   <= nxt_oe;
      ptr_ff  <= nxt_ptr;
      wd_ff   <= nxt_wd;
      we_ff   <= nxt_we;
      busy_ff <= nxt_st != S_IDLE;
    end
  end

  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = oe_ff;
  assign ptr          = ptr_ff;
  assign wr_data      = wd_ff;
  assign wr_en        = we_ff;
  assign busy         = busy_ff;
endmodule // rtci_dev
`default_nettype wire

// [testbench/rtci_bus_assertions.sv]
// Purpose: Bus-level checks on the two-wire link
// Assumes: Host quarter period set to 8 clocks
// Notes:   Watches resolved lines and output enables
`timescale 1ns/1ps
`default_nettype none
module rtci_bus_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe
);
  // ------------------------------------------------------------------
  // Clocking
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_dev_drive_low: assert property ($rose(s_sda_oe) |-> !scl)
    else $error("device pulled data with clock high");
  a_dev_release_low: assert property ($fell(s_sda_oe) |-> !scl)
    else $error("device released data with clock high");
  a_dev_hold_high: assert property (s_sda_oe && $rose(scl) |->
    s_sda_oe[*8]) else $error("device data moved in clock high");
  a_start_scl_fall: assert property ($fell(sda) && scl |->
    scl[*4] ##[1:12] !scl) else $error("bad start shape");
  a_stop_idle_hold: assert property ($rose(sda) && scl |->
    (scl && sda)[*6]) else $error("bus not idle after stop");
  a_scl_high_min: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> (!scl)[*8])
    else $error("clock low phase too short");
  a_dev_drive_bound: assert property ($rose(s_sda_oe) |->
    ##[1:400] !s_sda_oe) else $error("device holds data too long");
  // ------------------------------------------------------------------
  // Covers
  // ------------------------------------------------------------------
  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
  c_dev_ack: cover property ($rose(s_sda_oe));
  c_both_low: cover property (s_sda_oe && m_sda_oe && !m_scl_oe);
endmodule // rtci_bus_assertions
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: Self-checking bench, host end driving device end
// Assumes: Register file behind the device kept in the bench
// Notes:   Quarter period shortened to 8 clocks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtci_pkg::*;
  logic        clk         = 1'b0;
  logic        reset       = 1'b1;
  logic        on_battery  = 1'b0;
  logic        cmd_valid   = 1'b0;
  rtci_cmd_t   cmd_code    = CMD_START;
  logic [7:0]  cmd_data    = 8'h00;
  logic        cmd_last    = 1'b0;
  logic        cmd_ready, done, nack, refused, wr_en, busy;
  logic [7:0]  rd_byte;
  logic [7:0]  wr_data;
  logic [5:0]  ptr;
  logic [7:0]  regs [48];
  logic [7:0]  mem [48];
  logic [31:0] seed        = 32'h5be8;
  logic [7:0]  got;
  logic        gn;
  logic        gr;
  int          mptr        = 0;
  int          wr_cnt      = 0;
  int          fail_count  = 0;
  int          check_count = 0;
  wire  [5:0]  wa = (ptr == 6'h00) ? 6'h2f : ptr - 6'h01;
  wire  [7:0]  rd_data = regs[ptr];

  rtci_if bus_if ();
  rtci_dev i_rtci_dev (.clk(clk), .reset(reset), .ce(1'b1),
    .on_battery(on_battery), .bus(bus_if.dev), .rd_data(rd_data),
    .ptr(ptr), .wr_data(wr_data), .wr_en(wr_en), .busy(busy));
  rtci_host #(.QTR(16'h0008)) i_rtci_host (.clk(clk), .reset(reset),
    .ce(1'b1), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .bus(bus_if.host),
    .cmd_ready(cmd_ready), .done(done), .rd_byte(rd_byte),
    .nack(nack), .refused(refused));
  rtci_bus_assertions i_rtci_bus_assertions (.clk(clk), .reset(reset),
    .scl(bus_if.scl), .sda(bus_if.sda), .m_scl_oe(bus_if.m_scl_oe),
    .m_sda_oe(bus_if.m_sda_oe), .s_sda_oe(bus_if.s_sda_oe));

  always #4 clk = ~clk;
  // ------------------------------------------------------------------
  // Register file behind the device
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (wr_en === 1'b1) begin
      regs[wa] <= wr_data;
      wr_cnt++;
    end
  end
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmd(input rtci_cmd_t c, input logic [7:0] d,
                     input logic l);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    cmd_last = l;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    got = rd_byte;
    gn = nack;
    gr = refused;
    chk({7'h00, n >= 4000}, 8'h00);
    @(negedge clk);
  endtask

  task automatic wr_seq(input logic [7:0] a, input logic [7:0] p,
                        input int k, input logic stp);
    logic       ok;
    logic [7:0] d;
    ok = (a === ADDR_WR) && (on_battery === 1'b0);
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, a, 1'b0);
    chk({7'h00, gn}, {7'h00, !ok});
    cmd(CMD_WRITE, p, 1'b0);
    chk({7'h00, gn}, {7'h00, !ok});
    chk({7'h00, busy}, {7'h00, ok});
    if (ok && p <= PTR_MAX) mptr = int'(p);
    for (int i = 0; i < k; i++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      cmd(CMD_WRITE, d, 1'b0);
      chk({7'h00, gn}, {7'h00, !ok});
      chk(got, d);
      if (ok && p <= PTR_MAX) begin
        mem[mptr] = d;
        mptr = (mptr + 1) % 48;
      end
    end
    if (stp) cmd(CMD_STOP, 8'h00, 1'b0);
  endtask

  task automatic rd_seq(input int k);
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, ADDR_RD, 1'b0);
    chk({7'h00, gn}, 8'h00);
    for (int i = 0; i < k; i++) begin
      cmd(CMD_READ, 8'h00, i == k - 1);
      chk(got, mem[mptr]);
      mptr = (mptr + 1) % 48;
    end
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int snap;
    for (int i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      regs[i] = seed[7:0];
      mem[i] = seed[7:0];
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk({2'h0, ptr}, 8'h00);
    repeat (4) @(negedge clk);
    wr_seq(ADDR_WR, 8'h2e, 3, 1'b1);
    chk({2'h0, ptr}, 8'(mptr));
    wr_seq(ADDR_WR, 8'h2f, 0, 1'b0);
    rd_seq(3);
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk({2'h0, ptr}, 8'(mptr));
    snap = wr_cnt;
    wr_seq(ADDR_WR, 8'h30, 2, 1'b1);
    chk(8'(wr_cnt - snap), 8'h00);
    wr_seq(8'ha4, 8'h00, 1, 1'b1);
    on_battery = 1'b1;
    repeat (4) @(negedge clk);
    wr_seq(ADDR_WR, 8'h00, 1, 1'b1);
    on_battery = 1'b0;
    repeat (4) @(negedge clk);
    chk({2'h0, ptr}, 8'(mptr));
    for (int j = 0; j < 4; j++) begin
      seed = lfsr(seed);
      wr_seq(ADDR_WR, {2'b00, seed[5:0]}, int'(seed[9:8]), 1'b1);
      wr_seq(ADDR_WR, {2'b00, seed[13:8]}, 0, 1'b0);
      rd_seq(int'(seed[17:16]) + 1);
      cmd(CMD_STOP, 8'h00, 1'b0);
    end
    rd_seq(1);
    cmd(CMD_WRITE, 8'h55, 1'b0);
    chk({7'h00, gr}, 8'h01);
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk({6'h00, bus_if.scl, bus_if.sda}, 8'h03);
    chk({7'h00, busy}, 8'h00);
    for (int i = 0; i < 48; i++) chk(regs[i], mem[i]);
    report_and_stop;
  end

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
